//--- design/dac_output_latch_control.sv
// top of the dac output latch control: serial target, buffered and active channel settings
// assumes latch, address and high-voltage flags arrive asynchronously; scl is driven by the host
//
// Notes on behaviour
// - odd latch moves odd channels' buffered settings to their outputs.
// - even latch moves even channels' buffered settings to their outputs.
// - latch high: writes land in buffers, active outputs keep their settings.
// - latch falling copies buffered code, reference, power-down and gain to outputs.
// - latch low: every volatile write reaches the active outputs at once, except even channels while the high-voltage input is high.
// - a rise then fall of the latch reloads outputs from buffers.
// - high-voltage input enables nonvolatile writes and also holds the even group like the even latch.
// - serial port is target only and never drives scl.
// - sda sampled on scl rise; device changes sda on scl fall.
// - address bits zero and one come from the two select inputs.
// - reference select: supply, band gap driving pin, or pin buffered/unbuffered.
// - gain bit gives unity or double with pin or band gap reference.
// - power-down ties output to low or high pull-down or open.
// - select pins override the stored address bits zero and one.
`timescale 1ns/1ps
module dac_output_latch_control #(
  parameter int         CHANNELS          = dolc_pkg::CHANNELS_DEFAULT,
  parameter int         CODE_BITS         = dolc_pkg::CODE_BITS_DEFAULT,
  parameter logic [4:0] ADDR_UPPER        = dolc_pkg::ADDR_UPPER_DEFAULT,
  parameter bit         ADDR_PINS_PRESENT = 1'b1
) (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          scl_pin,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe,
  input  wire logic                          even_channel_latch,
  input  wire logic                          odd_channel_latch,
  input  wire logic                          high_voltage_program_input,
  input  wire logic                          addr_select_bit_zero,
  input  wire logic                          addr_select_bit_one,
  input  wire logic                          stored_addr_bit_zero,
  input  wire logic                          stored_addr_bit_one,
  output logic [6:0]                         target_address,
  output logic [CHANNELS*CODE_BITS-1:0]      active_code,
  output logic [2*CHANNELS-1:0]              reference_source_select,
  output logic [2*CHANNELS-1:0]              powerdown_termination_select,
  output logic [CHANNELS-1:0]                output_gain_select,
  output logic [CHANNELS-1:0]                amp_drive_enable,
  output logic [CHANNELS-1:0]                pulldown_low_ohm_enable,
  output logic [CHANNELS-1:0]                pulldown_high_ohm_enable,
  output logic [CHANNELS-1:0]                gain_double,
  output logic [1:0]                         reference_pin_drive_enable,
  output logic [1:0]                         reference_pin_connect,
  output logic [1:0]                         reference_pin_buffer_enable,
  output logic                               nv_write_strobe,
  output logic [2:0]                         nv_write_chan,
  output logic [1:0]                         nv_write_field,
  output logic [15:0]                        nv_write_data
);
  localparam int NSYNC = 5;
  localparam int IX_EVEN = 0;
  localparam int IX_ODD = 1;
  localparam int IX_HV = 2;
  localparam int IX_A0 = 3;
  localparam int IX_A1 = 4;

  dolc_wr_if wr ();

  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] filt;
  logic [NSYNC-1:0] raw_in;
  logic [1:0]       latch_held;
  logic [1:0]       next_ref_drive;
  logic [1:0]       next_ref_connect;
  logic [1:0]       next_ref_buffer;

  logic [CODE_BITS-1:0] buf_code [CHANNELS];
  logic [1:0]           buf_ref  [CHANNELS];
  logic [1:0]           buf_pd   [CHANNELS];
  logic                 buf_gain [CHANNELS];
  logic [CODE_BITS-1:0] act_code [CHANNELS];
  logic [1:0]           act_ref  [CHANNELS];
  logic [1:0]           act_pd   [CHANNELS];
  logic                 act_gain [CHANNELS];

  // true when a volatile write targets this channel
  function automatic logic chan_hit(input logic v, input logic nv, input logic [2:0] c,
                                    input int idx);
    chan_hit = v && !nv && (int'(c) == idx);
  endfunction : chan_hit

  // gain only acts with the reference pin or band gap as source
  function automatic logic gain_applies(input logic [1:0] ref_sel);
    gain_applies = (ref_sel != dolc_pkg::REF_SUPPLY);
  endfunction : gain_applies

  assign raw_in = {addr_select_bit_one, addr_select_bit_zero, high_voltage_program_input,
                   odd_channel_latch, even_channel_latch};

  // three flip-flops per async input; level taken once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          filt[gi]  <= 1'b0;
        end else begin
          sync1[gi] <= raw_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) filt[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  // a high-voltage level on the shared pin also holds the even group
  assign latch_held[0] = filt[IX_EVEN] | filt[IX_HV];
  assign latch_held[1] = filt[IX_ODD];

  // pins win over stored bits when the package has them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      target_address <= {ADDR_UPPER, 2'h0};
    end else if (ADDR_PINS_PRESENT) begin
      target_address <= {ADDR_UPPER, filt[IX_A1], filt[IX_A0]};
    end else begin
      target_address <= {ADDR_UPPER, stored_addr_bit_one, stored_addr_bit_zero};
    end
  end

  // open-drain data line; the block never drives the clock line
  assign sda_out = 1'b0;

  dolc_i2c_target u_target (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .scl_pin     (scl_pin),
    .sda_pin_in  (sda_in),
    .sda_pin_oe  (sda_oe),
    .own_address (target_address),
    .wr          (wr.src)
  );

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      // even channels follow the even latch, odd channels the odd latch
      localparam int GRP = ch % 2;

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          buf_code[ch] <= CODE_BITS'(dolc_pkg::RST_CODE);
          buf_ref[ch]  <= dolc_pkg::RST_REF;
          buf_pd[ch]   <= dolc_pkg::RST_PD;
          buf_gain[ch] <= dolc_pkg::RST_GAIN;
        end else if (chan_hit(wr.valid, wr.nv, wr.chan, ch)) begin
          case (wr.field)
            dolc_pkg::FIELD_CODE: begin
              buf_code[ch] <= wr.data[CODE_BITS-1:0];
            end
            dolc_pkg::FIELD_REF: begin
              buf_ref[ch] <= wr.data[1:0];
            end
            dolc_pkg::FIELD_PD: begin
              buf_pd[ch] <= wr.data[1:0];
            end
            default: begin
              buf_gain[ch] <= wr.data[0];
            end
          endcase
        end
      end

      // level-sensitive transfer: held high freezes, low follows the buffers
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          act_code[ch] <= CODE_BITS'(dolc_pkg::RST_CODE);
          act_ref[ch]  <= dolc_pkg::RST_REF;
          act_pd[ch]   <= dolc_pkg::RST_PD;
          act_gain[ch] <= dolc_pkg::RST_GAIN;
        end else if (!latch_held[GRP]) begin
          act_code[ch] <= buf_code[ch];
          act_ref[ch]  <= buf_ref[ch];
          act_pd[ch]   <= buf_pd[ch];
          act_gain[ch] <= buf_gain[ch];
        end
      end

      // analog controls derived from the active settings
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          amp_drive_enable[ch]         <= 1'b0;
          pulldown_low_ohm_enable[ch]  <= 1'b0;
          pulldown_high_ohm_enable[ch] <= 1'b0;
          gain_double[ch]              <= 1'b0;
        end else begin
          amp_drive_enable[ch]         <= (act_pd[ch] == dolc_pkg::PD_NORMAL);
          pulldown_low_ohm_enable[ch]  <= (act_pd[ch] == dolc_pkg::PD_LOW_OHM);
          pulldown_high_ohm_enable[ch] <= (act_pd[ch] == dolc_pkg::PD_HIGH_OHM);
          gain_double[ch]              <= act_gain[ch] & gain_applies(act_ref[ch]);
        end
      end

      assign active_code[ch*CODE_BITS +: CODE_BITS]     = act_code[ch];
      assign reference_source_select[2*ch +: 2]         = act_ref[ch];
      assign powerdown_termination_select[2*ch +: 2]    = act_pd[ch];
      assign output_gain_select[ch]                     = act_gain[ch];
    end
  endgenerate

  // reference pin g serves the channels of group g
  always_comb begin
    next_ref_drive   = 2'h0;
    next_ref_connect = 2'h0;
    next_ref_buffer  = 2'h0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (act_ref[i] == dolc_pkg::REF_BANDGAP) begin
        next_ref_drive[i%2] = 1'b1;
      end else if (act_ref[i] == dolc_pkg::REF_PIN_BUF) begin
        next_ref_connect[i%2] = 1'b1;
        next_ref_buffer[i%2]  = 1'b1;
      end else if (act_ref[i] == dolc_pkg::REF_PIN_UNBUF) begin
        next_ref_connect[i%2] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reference_pin_drive_enable  <= 2'h0;
      reference_pin_connect       <= 2'h0;
      reference_pin_buffer_enable <= 2'h0;
    end else begin
      reference_pin_drive_enable  <= next_ref_drive;
      reference_pin_connect       <= next_ref_connect;
      reference_pin_buffer_enable <= next_ref_buffer;
    end
  end

  // nonvolatile writes pass only while the high-voltage flag is present
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      nv_write_strobe <= 1'b0;
      nv_write_chan   <= 3'h0;
      nv_write_field  <= 2'h0;
      nv_write_data   <= 16'h0000;
    end else begin
      nv_write_strobe <= wr.valid & wr.nv & filt[IX_HV];
      if (wr.valid && wr.nv && filt[IX_HV]) begin
        nv_write_chan  <= wr.chan;
        nv_write_field <= wr.field;
        nv_write_data  <= wr.data;
      end
    end
  end
endmodule : dac_output_latch_control

//--- design/dolc_pkg.sv
// package for the dac output latch control block: field codes, command layout, reset values
// assumes every user writes dolc_pkg::name and imports nothing
package dolc_pkg;
  localparam int         CHANNELS_DEFAULT   = 8;
  localparam int         CODE_BITS_DEFAULT  = 12;
  localparam int         SYNC_STAGES        = 3;
  // upper five address bits; the value is arbitrary
  localparam logic [4:0] ADDR_UPPER_DEFAULT = 5'h0C;

  // command byte layout
  localparam int         CMD_NV_BIT         = 7;
  localparam int         CMD_CHAN_LSB       = 4;
  localparam int         CMD_FIELD_LSB      = 0;

  // field selected by a command
  localparam logic [1:0] FIELD_CODE         = 2'h0;
  localparam logic [1:0] FIELD_REF          = 2'h1;
  localparam logic [1:0] FIELD_PD           = 2'h2;
  localparam logic [1:0] FIELD_GAIN         = 2'h3;

  // reference source encodings
  localparam logic [1:0] REF_SUPPLY         = 2'h0;
  localparam logic [1:0] REF_BANDGAP        = 2'h1;
  localparam logic [1:0] REF_PIN_UNBUF      = 2'h2;
  localparam logic [1:0] REF_PIN_BUF        = 2'h3;

  // power-down termination encodings
  localparam logic [1:0] PD_NORMAL          = 2'h0;
  localparam logic [1:0] PD_LOW_OHM         = 2'h1;
  localparam logic [1:0] PD_HIGH_OHM        = 2'h2;
  localparam logic [1:0] PD_OPEN            = 2'h3;

  // reset values of buffered and active settings
  localparam logic       RST_GAIN           = 1'b0;
  localparam logic [1:0] RST_REF            = 2'h0;
  localparam logic [1:0] RST_PD             = 2'h0;
  localparam int         RST_CODE           = 0;
endpackage : dolc_pkg

//--- design/dolc_wr_if.sv
// interface carrying one decoded register write from the serial target to the latch logic
// assumes both ends sit on ref_clk; valid is a one-cycle pulse
`timescale 1ns/1ps
interface dolc_wr_if;
  logic        valid;
  logic        nv;
  logic [2:0]  chan;
  logic [1:0]  field;
  logic [15:0] data;
  modport src (output valid, output nv, output chan, output field, output data);
  modport dst (input valid, input nv, input chan, input field, input data);
endinterface : dolc_wr_if

//--- design/dolc_i2c_target.sv
// i2c target engine: address match, command byte, data byte pairs, write pulses
// assumes scl and sda arrive asynchronously and are sampled by ref_clk
`timescale 1ns/1ps
module dolc_i2c_target (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       scl_pin,
  input  wire logic       sda_pin_in,
  output logic            sda_pin_oe,
  input  wire logic [6:0] own_address,
  dolc_wr_if.src          wr
);
  typedef enum {DOLC_IDLE, DOLC_BITS, DOLC_ACK} dolc_bit_state_t;
  typedef enum {DOLC_ADDR, DOLC_CMD, DOLC_HI, DOLC_LO} dolc_byte_stage_t;

  dolc_bit_state_t  state;
  dolc_byte_stage_t stage;
  logic [dolc_pkg::SYNC_STAGES-1:0] scl_s;
  logic [dolc_pkg::SYNC_STAGES-1:0] sda_s;
  logic       scl_f;
  logic       sda_f;
  logic       scl_prev;
  logic       sda_prev;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] cmd;
  logic [7:0] hi_byte;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;

  // three-stage sampling, a level counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_s    <= '1;
      sda_s    <= '1;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_s    <= {scl_s[1:0], scl_pin};
      sda_s    <= {sda_s[1:0], sda_pin_in};
      if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  assign scl_rise   = scl_f & ~scl_prev;
  assign scl_fall   = ~scl_f & scl_prev;
  assign start_seen = scl_f & scl_prev & sda_prev & ~sda_f;
  assign stop_seen  = scl_f & scl_prev & ~sda_prev & sda_f;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state      <= DOLC_IDLE;
      stage      <= DOLC_ADDR;
      sda_pin_oe <= 1'b0;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      cmd        <= 8'h00;
      hi_byte    <= 8'h00;
      wr.valid   <= 1'b0;
      wr.nv      <= 1'b0;
      wr.chan    <= 3'h0;
      wr.field   <= 2'h0;
      wr.data    <= 16'h0000;
    end else begin
      wr.valid <= 1'b0;
      if (start_seen) begin
        state      <= DOLC_BITS;
        stage      <= DOLC_ADDR;
        bit_cnt    <= 4'h0;
        sda_pin_oe <= 1'b0;
      end else if (stop_seen) begin
        state      <= DOLC_IDLE;
        sda_pin_oe <= 1'b0;
      end else begin
        case (state)
          DOLC_BITS: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              shreg   <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (stage == DOLC_ADDR) begin
                // only writes to our own address are acknowledged
                if (shreg[7:1] == own_address && !shreg[0]) begin
                  sda_pin_oe <= 1'b1;
                  state      <= DOLC_ACK;
                  stage      <= DOLC_CMD;
                end else begin
                  state <= DOLC_IDLE;
                end
              end else begin
                sda_pin_oe <= 1'b1;
                state      <= DOLC_ACK;
                case (stage)
                  DOLC_CMD: begin
                    cmd   <= shreg;
                    stage <= DOLC_HI;
                  end
                  DOLC_HI: begin
                    hi_byte <= shreg;
                    stage   <= DOLC_LO;
                  end
                  default: begin
                    wr.valid <= 1'b1;
                    wr.nv    <= cmd[dolc_pkg::CMD_NV_BIT];
                    wr.chan  <= cmd[dolc_pkg::CMD_CHAN_LSB +: 3];
                    wr.field <= cmd[dolc_pkg::CMD_FIELD_LSB +: 2];
                    wr.data  <= {hi_byte, shreg};
                    stage    <= DOLC_HI;
                  end
                endcase
              end
            end
          end
          DOLC_ACK: begin
            if (scl_fall) begin
              sda_pin_oe <= 1'b0;
              state      <= DOLC_BITS;
            end
          end
          default: begin
            state <= DOLC_IDLE;
          end
        endcase
      end
    end
  end
endmodule : dolc_i2c_target

//--- tb/dolc_asserts.sv
// checker: derived outputs, group holds, address, ack timing
// assumes it is bound to the top module
`timescale 1ns/1ps
module dolc_asserts #(
  parameter int         CHANNELS   = 8,
  parameter int         CODE_BITS  = 12,
  parameter logic [4:0] ADDR_UPPER = 5'h0C
) (
  input wire logic                     ref_clk,
  input wire logic                     sys_rst,
  input wire logic                     scl_pin,
  input wire logic                     sda_oe,
  input wire logic                     even_channel_latch,
  input wire logic                     odd_channel_latch,
  input wire logic                     high_voltage_program_input,
  input wire logic                     addr_select_bit_zero,
  input wire logic                     addr_select_bit_one,
  input wire logic [6:0]               target_address,
  input wire logic [CHANNELS*CODE_BITS-1:0] active_code,
  input wire logic [2*CHANNELS-1:0]    reference_source_select,
  input wire logic [2*CHANNELS-1:0]    powerdown_termination_select,
  input wire logic [CHANNELS-1:0]      output_gain_select,
  input wire logic [CHANNELS-1:0]      amp_drive_enable,
  input wire logic [CHANNELS-1:0]      pulldown_low_ohm_enable,
  input wire logic [CHANNELS-1:0]      pulldown_high_ohm_enable,
  input wire logic [CHANNELS-1:0]      gain_double,
  input wire logic [1:0]               reference_pin_drive_enable,
  input wire logic [1:0]               reference_pin_connect,
  input wire logic [1:0]               reference_pin_buffer_enable,
  input wire logic                     nv_write_strobe
);
  localparam int W = CODE_BITS + 5;
  logic [CHANNELS-1:0]   exp_amp, exp_lo, exp_hi, exp_gdbl;
  logic [1:0]            exp_drv, exp_con, exp_buf, pd, rf;
  logic [W-1:0]          ch;
  logic [CHANNELS*W-1:0] odd_vec, even_vec;
  always_comb begin
    exp_drv = '0;
    exp_con = '0;
    exp_buf = '0;
    for (int n = 0; n < CHANNELS; n++) begin
      pd = powerdown_termination_select[2*n +: 2];
      rf = reference_source_select[2*n +: 2];
      exp_amp[n] = (pd == dolc_pkg::PD_NORMAL);
      exp_lo[n] = (pd == dolc_pkg::PD_LOW_OHM);
      exp_hi[n] = (pd == dolc_pkg::PD_HIGH_OHM);
      exp_gdbl[n] = output_gain_select[n] && (rf != dolc_pkg::REF_SUPPLY);
      exp_drv[n%2] |= (rf == dolc_pkg::REF_BANDGAP);
      exp_con[n%2] |= (rf == dolc_pkg::REF_PIN_UNBUF) || (rf == dolc_pkg::REF_PIN_BUF);
      exp_buf[n%2] |= (rf == dolc_pkg::REF_PIN_BUF);
      ch = {active_code[n*CODE_BITS +: CODE_BITS], rf, pd, output_gain_select[n]};
      odd_vec[n*W +: W] = (n % 2 == 1) ? ch : '0;
      even_vec[n*W +: W] = (n % 2 == 0) ? ch : '0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  gain_double_a: assert property (
    !$past(sys_rst) |-> gain_double == $past(exp_gdbl)) else $error("gain double wrong");
  amp_drive_a: assert property (
    !$past(sys_rst) |-> amp_drive_enable == $past(exp_amp)) else $error("amp drive wrong");
  pulldown_sel_a: assert property (
    !$past(sys_rst) |-> {pulldown_low_ohm_enable, pulldown_high_ohm_enable}
      == $past({exp_lo, exp_hi})) else $error("pull-down select wrong");
  ref_pin_a: assert property (
    !$past(sys_rst) |-> {reference_pin_drive_enable, reference_pin_connect,
      reference_pin_buffer_enable} == $past({exp_drv, exp_con, exp_buf}))
    else $error("reference pin control wrong");
  addr_pins_a: assert property (
    ($stable(addr_select_bit_zero) && $stable(addr_select_bit_one)) [*8] |->
      target_address == {ADDR_UPPER, addr_select_bit_one, addr_select_bit_zero})
    else $error("target address wrong");
  ack_on_fall_a: assert property (
    $changed(sda_oe) |-> !$past(scl_pin, 3)) else $error("sda changed outside scl low");
  odd_hold_a: assert property (
    odd_channel_latch [*7] |-> $stable(odd_vec)) else $error("odd group moved while held");
  even_hold_a: assert property (
    (even_channel_latch || high_voltage_program_input) [*7] |-> $stable(even_vec))
    else $error("even group moved while held");
  nv_pulse_a: assert property (
    nv_write_strobe |-> $past(high_voltage_program_input, 3) ##1 !nv_write_strobe)
    else $error("nonvolatile strobe without high voltage");
endmodule : dolc_asserts

bind dac_output_latch_control dolc_asserts #(
  .CHANNELS(CHANNELS), .CODE_BITS(CODE_BITS), .ADDR_UPPER(ADDR_UPPER)
) u_chk (.*);

//--- tb/dolc_host_model.sv
// i2c host model: makes scl, pulls sda low, collects acknowledges
// assumes an open-drain sda with pull-up in the bench
`timescale 1ns/1ps
module dolc_host_model (
  output logic      scl_pin,
  output logic      sda_pull,
  input  wire logic sda_level
);
  // scl stands high between frames
  initial {scl_pin, sda_pull} = 2'b10;
  // 800 ns bit: scl low 600 ns so the target's ack settles before the rise
  task automatic pulse(input logic pull, output logic seen);
    sda_pull = pull;
    #300 scl_pin = 1'b1;
    #100 seen = (sda_level === 1'b0);
    #100 scl_pin = 1'b0;
    #300;
  endtask : pulse
  task automatic write_frame(input logic [6:0] addr, input logic [7:0] cmd,
                             input logic [15:0] data, output logic [3:0] acks);
    logic [35:0] bits;
    logic        s;
    bits = {addr, 2'b01, cmd, 1'b1, data[15:8], 1'b1, data[7:0], 1'b1};
    sda_pull = 1'b1;
    #400 scl_pin = 1'b0;
    #300;
    for (int i = 35; i >= 0; i--) begin
      pulse(~bits[i], s);
      if (i % 9 == 0) acks[i/9] = s;
    end
    sda_pull = 1'b1;
    #300 scl_pin = 1'b1;
    #400 sda_pull = 1'b0;
    #400;
  endtask : write_frame
endmodule : dolc_host_model

//--- tb/tb.sv
// self-checking bench for the dac output latch control
// assumes the host model drives the serial link
`timescale 1ns/1ps
module tb;
  localparam int CH = dolc_pkg::CHANNELS_DEFAULT;
  localparam int CB = dolc_pkg::CODE_BITS_DEFAULT;
  typedef struct packed {logic [CB-1:0] code; logic [1:0] rf; logic [1:0] pd; logic gain;} dolc_ch_t;
  typedef struct packed {logic [2:0] ch; logic [1:0] fld; logic [15:0] d;} dolc_row_t;
  logic             ref_clk, sys_rst, scl_pin, sda_pull, sda_out, sda_oe, nv_write_strobe;
  logic             even_channel_latch, odd_channel_latch, high_voltage_program_input;
  logic             addr_select_bit_zero, addr_select_bit_one;
  logic             stored_addr_bit_zero, stored_addr_bit_one;
  logic [6:0]       target_address;
  logic [CH*CB-1:0] active_code;
  logic [2*CH-1:0]  reference_source_select, powerdown_termination_select;
  logic [CH-1:0]    output_gain_select, amp_drive_enable, gain_double;
  logic [CH-1:0]    pulldown_low_ohm_enable, pulldown_high_ohm_enable;
  logic [1:0]       reference_pin_drive_enable, reference_pin_connect;
  logic [1:0]       reference_pin_buffer_enable, nv_write_field;
  logic [2:0]       nv_write_chan;
  logic [15:0]      nv_write_data;
  logic [3:0]       acks;
  dolc_ch_t         bufd [CH];
  dolc_ch_t         act [CH];
  int               error_cnt, check_count, strobes, s0;
  wire              sda_line = ~((sda_oe & ~sda_out) | sda_pull);
  dolc_row_t        rows [10] = '{'{3'h0, dolc_pkg::FIELD_CODE, 16'h0ABC},
    '{3'h1, dolc_pkg::FIELD_REF, 16'h0001}, '{3'h1, dolc_pkg::FIELD_GAIN, 16'h0001},
    '{3'h2, dolc_pkg::FIELD_GAIN, 16'h0001}, '{3'h3, dolc_pkg::FIELD_PD, 16'h0001},
    '{3'h4, dolc_pkg::FIELD_PD, 16'h0002}, '{3'h5, dolc_pkg::FIELD_PD, 16'h0003},
    '{3'h6, dolc_pkg::FIELD_REF, 16'h0003}, '{3'h7, dolc_pkg::FIELD_REF, 16'h0002},
    '{3'h7, dolc_pkg::FIELD_CODE, 16'hFFFF}};
  dac_output_latch_control dut (.*, .sda_in(sda_line));
  dolc_host_model host (.scl_pin, .sda_pull, .sda_level(sda_line));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (nv_write_strobe === 1'b1) strobes <= strobes + 1;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic check_all();
    logic [1:0] drv, con, bf;
    drv = '0;
    con = '0;
    bf = '0;
    for (int n = 0; n < CH; n++) begin
      check(active_code[n*CB +: CB], act[n].code, "code");
      check(reference_source_select[2*n +: 2], act[n].rf, "ref");
      check(powerdown_termination_select[2*n +: 2], act[n].pd, "pd");
      check(output_gain_select[n], act[n].gain, "gain");
      check(gain_double[n], act[n].gain && act[n].rf != 2'h0, "double");
      check(amp_drive_enable[n], act[n].pd == 2'h0, "amp");
      check(pulldown_low_ohm_enable[n], act[n].pd == 2'h1, "low");
      check(pulldown_high_ohm_enable[n], act[n].pd == 2'h2, "high");
      drv[n%2] |= act[n].rf == 2'h1;
      con[n%2] |= act[n].rf[1];
      bf[n%2] |= act[n].rf == 2'h3;
    end
    check({reference_pin_drive_enable, reference_pin_connect,
           reference_pin_buffer_enable}, {drv, con, bf}, "ref pin");
  endtask : check_all
  task automatic wr(input logic nv, input dolc_row_t r);
    host.write_frame({dolc_pkg::ADDR_UPPER_DEFAULT, addr_select_bit_one, addr_select_bit_zero},
                     {nv, r.ch, 2'b00, r.fld}, r.d, acks);
    check(acks, 4'hF, "ack");
    if (!nv) begin
      case (r.fld)
        dolc_pkg::FIELD_CODE: bufd[r.ch].code = r.d[CB-1:0];
        dolc_pkg::FIELD_REF: bufd[r.ch].rf = r.d[1:0];
        dolc_pkg::FIELD_PD: bufd[r.ch].pd = r.d[1:0];
        default: bufd[r.ch].gain = r.d[0];
      endcase
      if (!(r.ch[0] ? odd_channel_latch : even_channel_latch | high_voltage_program_input))
        act[r.ch] = bufd[r.ch];
    end
    tick(6);
    check_all();
  endtask : wr
  task automatic release_grp(input int par);
    tick(8);
    for (int n = par; n < CH; n += 2) act[n] = bufd[n];
    check_all();
  endtask : release_grp
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end
  initial begin
    {sys_rst, stored_addr_bit_zero, addr_select_bit_one} = 3'b111;
    {even_channel_latch, odd_channel_latch, high_voltage_program_input} = 3'b000;
    {addr_select_bit_zero, stored_addr_bit_one} = 2'b00;
    for (int n = 0; n < CH; n++) {bufd[n], act[n]} = '0;
    tick(8);
    sys_rst = 1'b0;
    tick(8);
    check(target_address, {dolc_pkg::ADDR_UPPER_DEFAULT, 2'b10}, "addr");
    check_all();
    foreach (rows[i]) wr(1'b0, rows[i]);
    odd_channel_latch = 1'b1;
    tick(8);
    wr(1'b0, '{3'h1, dolc_pkg::FIELD_CODE, 16'h0123});
    wr(1'b0, '{3'h3, dolc_pkg::FIELD_PD, 16'h0000});
    wr(1'b0, '{3'h0, dolc_pkg::FIELD_CODE, 16'h0456});
    odd_channel_latch = 1'b0;
    release_grp(1);
    odd_channel_latch = 1'b1;
    tick(8);
    odd_channel_latch = 1'b0;
    release_grp(1);
    high_voltage_program_input = 1'b1;
    tick(8);
    s0 = strobes;
    wr(1'b1, '{3'h2, dolc_pkg::FIELD_REF, 16'h0003});
    check(strobes - s0, 1, "nv strobe");
    check({nv_write_chan, nv_write_field, nv_write_data}, {3'h2, 2'h1, 16'h0003}, "nv");
    wr(1'b0, '{3'h2, dolc_pkg::FIELD_CODE, 16'h0777});
    high_voltage_program_input = 1'b0;
    release_grp(0);
    s0 = strobes;
    wr(1'b1, '{3'h4, dolc_pkg::FIELD_CODE, 16'h0111});
    check(strobes - s0, 0, "nv dropped");
    host.write_frame(target_address ^ 7'h03, 8'h00, 16'h0999, acks);
    check(acks, 4'h0, "refused");
    check_all();
    {addr_select_bit_one, addr_select_bit_zero} = 2'b01;
    tick(10);
    check(target_address, {dolc_pkg::ADDR_UPPER_DEFAULT, 2'b01}, "addr");
    wr(1'b0, '{3'h5, dolc_pkg::FIELD_GAIN, 16'h0001});
    sys_rst = 1'b1;
    tick(4);
    check(sda_oe, 1'b0, "sda_oe");
    sys_rst = 1'b0;
    for (int n = 0; n < CH; n++) {bufd[n], act[n]} = '0;
    tick(8);
    check_all();
    finish_test();
  end
endmodule : tb
